// [dv/pwis_port_bench.sv]
// self-checking bench for the per-port wake and interrupt status block
`default_nettype none
module pwis_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [47:0] SW_MAC = 48'h0a0b_0c0d_0e0f;
    logic        clock     = 1'b0;
    logic        nrst      = 1'b0;
    logic [15:0] addr      = 16'h0000;
    logic        rd        = 1'b0;
    logic        wr        = 1'b0;
    logic [31:0] wdata     = 32'h0000_0000;
    logic [3:0]  ev        = 4'h0; // filter, frame, link, energy pulses
    logic [47:0] dst       = 48'h0;
    logic        ts        = 1'b0;
    logic        xc        = 1'b0;
    logic [31:0] rdata;
    logic        wait_req;
    logic        wake;
    logic        irq;
    logic        eirq;
    logic [3:0]  be        = 4'hf;
    logic [31:0] rdata_mac;
    logic        wake_mac;
    logic        irq_mac;
    int          err_count = 0;
    int          cmp_count = 0;
    int          cycles    = 0;
    pwis_port #(.PORT_IDX(4'h1)) dut (.clock(clock), .nrst(nrst), .avs_address(addr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be),
        .avs_readdata(rdata), .avs_waitrequest(wait_req), .wake_frame_seen(ev[2]),
        .wake_frame_dst(dst), .switch_mac_addr(SW_MAC), .link_up_seen(ev[1]),
        .energy_seen(ev[0]), .ts_irq_pending(ts), .xcvr_irq_pending(xc),
        .filter_irq_pulse(ev[3]), .wake_request_output(wake), .port_irq(irq), .evt_irq(eirq));
    // mac port page on the same bus; an unselected slave reads back zero
    pwis_port #(.PORT_IDX(4'h7)) dut_mac (.clock(clock), .nrst(nrst), .avs_address(addr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be),
        .avs_readdata(rdata_mac), .avs_waitrequest(), .wake_frame_seen(ev[2]),
        .wake_frame_dst(dst), .switch_mac_addr(SW_MAC), .link_up_seen(ev[1]),
        .energy_seen(ev[0]), .ts_irq_pending(ts), .xcvr_irq_pending(xc),
        .filter_irq_pulse(ev[3]), .wake_request_output(wake_mac), .port_irq(irq_mac),
        .evt_irq());
    always #10 clock = ~clock;
    // hang guard, far above the roughly 125 cycles the run needs
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            finish_test();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    // one bus access held until waitrequest is seen low; reads are compared
    task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d,
                       input string n = "", input logic [31:0] e = 32'h0);
        addr  <= a;
        wdata <= {24'h0, d};
        wr    <= w;
        rd    <= !w;
        @(posedge clock);
        while (wait_req !== 1'b0) @(posedge clock);
        if (!w) chk(n, e, rdata | rdata_mac);
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clock);
    endtask
    task automatic pulse(input logic [3:0] v);
        ev <= v;
        @(posedge clock);
        ev <= 4'h0;
        repeat (2) @(posedge clock);
    endtask
    task automatic t_wake;
        bus(1'b0, 16'h101f, 8'h0, "mask rst", 32'h0);
        bus(1'b1, 16'h1017, 8'h07);
        dst <= SW_MAC ^ 48'h1;
        pulse(4'h4);
        bus(1'b0, 16'h1013, 8'h0, "flag miss", 32'h0);
        dst <= SW_MAC;
        pulse(4'h4);
        chk("wake frame", 32'h1, {31'h0, wake});
        bus(1'b0, 16'h1013, 8'h0, "flag hit", 32'h4);
        bus(1'b1, 16'h1013, 8'h04);
        for (int b = 0; b < 2; b++) begin
            pulse(4'h1 << b);
            chk("wake src", 32'h1, {31'h0, wake});
            bus(1'b0, 16'h1013, 8'h0, "flag src", 32'h1 << b);
            bus(1'b1, 16'h1013, 8'h1 << b);
        end
        @(posedge clock);
        chk("wake clear", 32'h0, {31'h0, wake});
        bus(1'b1, 16'h1017, 8'h00);
        pulse(4'h7);
        chk("wake off", 32'h0, {31'h0, wake});
        bus(1'b0, 16'h1013, 8'h0, "flags all", 32'h7);
        bus(1'b1, 16'h1013, 8'h07);
        be <= 4'he;
        bus(1'b1, 16'h1017, 8'h07);
        be <= 4'hf;
        bus(1'b0, 16'h1017, 8'h0, "en lane", 32'h0);
    endtask
    task automatic t_irq;
        ts <= 1'b1;
        xc <= 1'b1;
        repeat (3) @(posedge clock);
        chk("irq live", 32'h1, {31'h0, irq});
        bus(1'b0, 16'h101b, 8'h0, "status", 32'h6);
        bus(1'b0, 16'h201b, 8'h0, "other page", 32'h0);
        bus(1'b1, 16'h101f, 8'h06);
        @(posedge clock);
        chk("irq masked", 32'h0, {31'h0, irq});
        ts <= 1'b0;
        xc <= 1'b0;
        pulse(4'h8);
        bus(1'b0, 16'h101b, 8'h0, "status filt", 32'h1);
        chk("irq filt", 32'h1, {31'h0, irq});
        bus(1'b1, 16'h101f, 8'h07);
        bus(1'b0, 16'h101b, 8'h0, "status tog", 32'h0);
    endtask
    // mac port page: frame wake works, transceiver sources stay zero
    task automatic t_mac;
        bus(1'b0, 16'h7013, 8'h0, "mac flags", 32'h4);
        bus(1'b1, 16'h7017, 8'h07);
        @(posedge clock);
        chk("mac wake", 32'h1, {31'h0, wake_mac});
        bus(1'b1, 16'h7013, 8'h07);
        @(posedge clock);
        chk("mac wake clr", 32'h0, {31'h0, wake_mac});
        ts <= 1'b1;
        xc <= 1'b1;
        pulse(4'h3);
        bus(1'b0, 16'h701b, 8'h0, "mac status", 32'h1);
        chk("mac irq filt", 32'h1, {31'h0, irq_mac});
        bus(1'b1, 16'h701f, 8'h01);
        bus(1'b0, 16'h701b, 8'h0, "mac status tog", 32'h0);
        chk("mac irq", 32'h0, {31'h0, irq_mac});
        chk("mac wake src", 32'h0, {31'h0, wake_mac});
        ts <= 1'b0;
        xc <= 1'b0;
    endtask
    // sticky event bits: read clears, mask gates the event line
    task automatic t_evt;
        bus(1'b0, 16'h10f0, 8'h0, "evt old", 32'hf);
        bus(1'b1, 16'h10f1, 8'h0f);
        pulse(4'h1);
        chk("evt irq", 32'h1, {31'h0, eirq});
        bus(1'b0, 16'h10f0, 8'h0, "evt stat", 32'h1);
        chk("evt irq off", 32'h0, {31'h0, eirq});
    endtask
    task automatic finish_test;
        if (err_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        t_wake();
        t_irq();
        t_mac();
        t_evt();
        finish_test();
    end
endmodule // pwis_port_bench
bind pwis_port pwis_port_properties #(.PORT_IDX(PORT_IDX)) u_props (.*);
`default_nettype wire

// [dv/pwis_port_properties.sv]
// concurrent checks on the ports of the wake and interrupt status block
`default_nettype none
module pwis_port_properties #(
    parameter logic [3:0] PORT_IDX = 4'h1
) (
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic [15:0] avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        wake_frame_seen,
    input wire logic [47:0] wake_frame_dst,
    input wire logic [47:0] switch_mac_addr,
    input wire logic        link_up_seen,
    input wire logic        energy_seen,
    input wire logic        ts_irq_pending,
    input wire logic        xcvr_irq_pending,
    input wire logic        filter_irq_pulse,
    input wire logic        wake_request_output,
    input wire logic        port_irq,
    input wire logic        evt_irq
);
    // shadow of mask and enables, taken only at completing writes
    logic [2:0] mask_q;
    logic [2:0] en_q;
    wire        wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
    wire        wr_mask = wr_done && avs_address == {PORT_IDX, 12'h01f};
    wire        quiet   = !ts_irq_pending && !xcvr_irq_pending && !filter_irq_pulse;
    // transceiver-only sources are ignored on the mac port page
    localparam logic IS_PHY = (PORT_IDX != 4'h7);
    always_ff @(posedge clock) begin
        if (!nrst) begin
            mask_q <= 3'h0;
            en_q   <= 3'h0;
        end else begin
            mask_q <= wr_mask ? avs_writedata[2:0] : mask_q;
            en_q   <= (wr_done && avs_address == {PORT_IDX, 12'h017}) ? avs_writedata[2:0] : en_q;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // event latched at one edge, output follows at the next; no clear write in between
    sequence latch_seq(logic e, logic n);
        (e && n) ##1 (n && !avs_write);
    endsequence
    a_frame_wake: assert property (
        latch_seq(wake_frame_seen && wake_frame_dst == switch_mac_addr, en_q[2])
        |=> wake_request_output) else $error("wake frame missed wake request");
    a_link_wake: assert property (
        latch_seq(link_up_seen && IS_PHY, en_q[1]) |=> wake_request_output)
        else $error("link missed wake");
    a_energy_wake: assert property (
        latch_seq(energy_seen && IS_PHY, en_q[0]) |=> wake_request_output)
        else $error("energy missed wake");
    a_wake_gated: assert property (
        (en_q == 3'h0) [*2] |-> !wake_request_output) else $error("wake with enables off");
    a_ts_irq: assert property (
        (IS_PHY && ts_irq_pending && !mask_q[2]) [*3] |-> port_irq)
        else $error("timestamp irq missed");
    a_xcvr_irq: assert property (
        (IS_PHY && xcvr_irq_pending && !mask_q[1]) [*3] |-> port_irq)
        else $error("transceiver irq missed");
    a_filter_irq: assert property (
        latch_seq(filter_irq_pulse, !mask_q[0]) |=> port_irq) else $error("filter irq missed");
    a_toggle_clear: assert property (
        (wr_mask && avs_writedata[0] != mask_q[0] && quiet) ##1 quiet [*2] |-> !port_irq)
        else $error("mask toggle left irq set");
    a_mask_all: assert property (
        (mask_q == 3'h7) [*2] |-> !port_irq) else $error("irq with all sources masked");
endmodule // pwis_port_properties
`default_nettype wire

// [rtl/pwis_port.sv]
// per-port wake event flags, wake request and port interrupt status with avalon slave
`default_nettype none

// How it works
// - wake frame to switch address sets flag 2
// - link up sets flag 1, write clears
// - cable energy sets flag 0, write clears
// - enable 2 routes frame flag to wake
// - enable 1 routes link flag to wake
// - enable 0 routes energy flag to wake
// - cleared enable blocks its source from wake
// - own status register at port offset 0x1b
// - status 2 is timestamp interrupt summary
// - status 1 is transceiver interrupt summary
// - filter table counter interrupt sets status 0
// - toggling filter mask bit clears status 0
// - mask bits active low, reset to zero
// - page 7 is mac port, 1-4 transceivers
module pwis_port #(
    parameter logic [3:0] PORT_IDX = 4'h1
) (
    input  wire logic        clock,
    input  wire logic        nrst,
    // avalon-mm slave, word addressed
    input  wire logic [15:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // event sources from the port logic
    input  wire logic        wake_frame_seen,
    input  wire logic [47:0] wake_frame_dst,
    input  wire logic [47:0] switch_mac_addr,
    input  wire logic        link_up_seen,
    input  wire logic        energy_seen,
    input  wire logic        ts_irq_pending,
    input  wire logic        xcvr_irq_pending,
    input  wire logic        filter_irq_pulse,
    // outputs
    output logic             wake_request_output,
    output logic             port_irq,
    output logic             evt_irq
);

    // refuse page numbers that have no port behind them, at elaboration
    if (!((PORT_IDX >= pwis_pkg::PORT_PHY_FIRST && PORT_IDX <= pwis_pkg::PORT_PHY_LAST)
          || PORT_IDX == pwis_pkg::PORT_MAC_IDX)) begin : g_bad_port_idx
        $error("pwis_port: PORT_IDX must be 1..4 or 7");
    end

    // page 7 is logical port 5, the external mac port
    localparam logic IS_MAC = (PORT_IDX == pwis_pkg::PORT_MAC_IDX);

    logic [2:0]  wake_flags_q;
    logic [2:0]  wake_flags_d;
    logic [2:0]  wake_en_q;
    logic [2:0]  wake_en_d;
    logic        filt_stat_q;
    logic        filt_stat_d;
    logic [2:0]  irq_mask_q;
    logic [2:0]  irq_mask_d;
    logic [3:0]  evt_stat_q;
    logic [3:0]  evt_stat_d;
    logic [3:0]  evt_mask_q;
    logic [3:0]  evt_mask_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        wait_q;
    logic        wait_d;
    logic        wake_q;
    logic        pirq_q;
    logic        eirq_q;

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    // one register of this port's page: page number, [11:8] clear, offset
    // other pages still get the handshake, so a shared bus never stalls
    function automatic logic reg_hit(input logic [15:0] a, input logic [7:0] o);
        reg_hit = (a[pwis_pkg::PAGE_LSB +: 4] == PORT_IDX)
                  && (a[11:8] == 4'h0)
                  && (a[7:0] == o);
    endfunction

    wire logic       req        = avs_read | avs_write;
    wire logic       sel_flags  = reg_hit(avs_address, pwis_pkg::OFF_WAKE_FLAGS);
    wire logic       sel_en     = reg_hit(avs_address, pwis_pkg::OFF_WAKE_EN);
    wire logic       sel_stat   = reg_hit(avs_address, pwis_pkg::OFF_IRQ_STAT);
    wire logic       sel_mask   = reg_hit(avs_address, pwis_pkg::OFF_IRQ_MASK);
    wire logic       sel_estat  = reg_hit(avs_address, pwis_pkg::OFF_EVT_STAT);
    wire logic       sel_emask  = reg_hit(avs_address, pwis_pkg::OFF_EVT_MASK);
    // the access completes on the edge where waitrequest is seen low
    wire logic       done       = req & ~wait_q;
    wire logic       lane0      = avs_byteenable[0];
    wire logic       wr_go      = done & avs_write & lane0;
    wire logic       rd_go      = done & avs_read;
    wire logic [7:0] wd         = avs_writedata[7:0];

    // ---------------------------------------------------------------
    // event qualification
    // ---------------------------------------------------------------
    // a wake frame counts only when aimed at the switch's own address
    wire logic frame_hit = wake_frame_seen & (wake_frame_dst == switch_mac_addr);
    // link and energy come from the transceiver; the mac port has none
    wire logic link_hit   = link_up_seen & ~IS_MAC;
    wire logic energy_hit = energy_seen & ~IS_MAC;

    wire logic [2:0] wake_set;
    assign wake_set[pwis_pkg::WAKE_FRAME_BIT]  = frame_hit;
    assign wake_set[pwis_pkg::WAKE_LINK_BIT]   = link_hit;
    assign wake_set[pwis_pkg::WAKE_ENERGY_BIT] = energy_hit;

    // write-one-to-clear; a new event in the same cycle keeps its flag
    wire logic [2:0] wake_clr = (wr_go & sel_flags) ? wd[2:0] : 3'h0;
    assign wake_flags_d = (wake_flags_q & ~wake_clr) | wake_set;

    // enables are plain read/write bits
    assign wake_en_d = (wr_go & sel_en) ? wd[2:0] : wake_en_q;

    // wake request only from flags whose enable is set
    wire logic wake_next = |(wake_flags_q & wake_en_q);

    // ---------------------------------------------------------------
    // port interrupt status and mask
    // ---------------------------------------------------------------
    // timestamp and transceiver bits are live summaries, zero on the mac port
    wire logic ts_bit   = ts_irq_pending & ~IS_MAC;
    wire logic xcvr_bit = xcvr_irq_pending & ~IS_MAC;

    assign irq_mask_d = (wr_go & sel_mask) ? wd[2:0] : irq_mask_q;

    // a mask write that flips bit 0 clears the filter status
    wire logic filt_toggle = wr_go & sel_mask
                           & (wd[pwis_pkg::IRQ_FILTER_BIT]
                              != irq_mask_q[pwis_pkg::IRQ_FILTER_BIT]);
    // set beats the toggle so a coincident interrupt is not lost
    assign filt_stat_d = filter_irq_pulse | (filt_stat_q & ~filt_toggle);

    wire logic [2:0] irq_stat;
    assign irq_stat[pwis_pkg::IRQ_FILTER_BIT] = filt_stat_q;
    assign irq_stat[pwis_pkg::IRQ_XCVR_BIT]   = xcvr_bit;
    assign irq_stat[pwis_pkg::IRQ_TS_BIT]     = ts_bit;

    // a zero mask bit lets the source through
    wire logic pirq_next = |(irq_stat & ~irq_mask_q);

    // ---------------------------------------------------------------
    // sticky event status, cleared by reading it
    // ---------------------------------------------------------------
    wire logic [3:0] evt_set;
    assign evt_set[pwis_pkg::EVT_ENERGY_BIT] = energy_hit;
    assign evt_set[pwis_pkg::EVT_LINK_BIT]   = link_hit;
    assign evt_set[pwis_pkg::EVT_FRAME_BIT]  = frame_hit;
    assign evt_set[pwis_pkg::EVT_FILTER_BIT] = filter_irq_pulse;

    // read-clear drops only the bits captured for this read; an event that
    // lands between capture and completion stays set for the next read
    wire logic       evt_rd  = rd_go & sel_estat;
    wire logic [3:0] evt_clr = evt_rd ? rdata_q[3:0] : 4'h0;
    assign evt_stat_d = (evt_stat_q & ~evt_clr) | evt_set;
    assign evt_mask_d = (wr_go & sel_emask) ? wd[3:0] : evt_mask_q;
    // evt mask is active high: one passes the bit
    wire logic eirq_next = |(evt_stat_d & evt_mask_q);

    // ---------------------------------------------------------------
    // read data mux, unmapped reads return zero
    // ---------------------------------------------------------------
    wire logic [7:0] rd_byte =
          sel_flags ? {5'h00, wake_flags_q}
        : sel_en    ? {5'h00, wake_en_q}
        : sel_stat  ? {5'h00, irq_stat}
        : sel_mask  ? {5'h00, irq_mask_q}
        : sel_estat ? {4'h0, evt_stat_q}
        : sel_emask ? {4'h0, evt_mask_q}
        : 8'h00;

    // data is captured while waiting so it stands at the completing edge
    assign rdata_d = (avs_read & wait_q) ? {24'h00_0000, rd_byte} : rdata_q;

    // one wait cycle per access, then waitrequest drops for one edge
    assign wait_d = ~(req & wait_q);

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    // bus handshake and read data
    always_ff @(posedge clock) begin
        if (!nrst) begin
            wait_q  <= pwis_pkg::RST_WAIT;
            rdata_q <= pwis_pkg::RST_RDATA;
        end else begin
            wait_q  <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    // wake flags and enables
    always_ff @(posedge clock) begin
        if (!nrst) begin
            wake_flags_q <= pwis_pkg::RST_WAKE_FLAGS;
            wake_en_q    <= pwis_pkg::RST_WAKE_EN;
            wake_q       <= pwis_pkg::RST_OUT;
        end else begin
            wake_flags_q <= wake_flags_d;
            wake_en_q    <= wake_en_d;
            wake_q       <= wake_next;
        end
    end

    // port interrupt status and mask, every source enabled after reset
    always_ff @(posedge clock) begin
        if (!nrst) begin
            filt_stat_q <= pwis_pkg::RST_FILT_STAT;
            irq_mask_q  <= pwis_pkg::RST_IRQ_MASK;
            pirq_q      <= pwis_pkg::RST_OUT;
        end else begin
            filt_stat_q <= filt_stat_d;
            irq_mask_q  <= irq_mask_d;
            pirq_q      <= pirq_next;
        end
    end

    // sticky events and their mask
    always_ff @(posedge clock) begin
        if (!nrst) begin
            evt_stat_q <= pwis_pkg::RST_EVT_STAT;
            evt_mask_q <= pwis_pkg::RST_EVT_MASK;
            eirq_q     <= pwis_pkg::RST_OUT;
        end else begin
            evt_stat_q <= evt_stat_d;
            evt_mask_q <= evt_mask_d;
            eirq_q     <= eirq_next;
        end
    end

    // outputs straight from flops
    assign avs_readdata        = rdata_q;
    assign avs_waitrequest     = wait_q;
    assign wake_request_output = wake_q;
    assign port_irq            = pirq_q;
    assign evt_irq             = eirq_q;

endmodule // pwis_port
`default_nettype wire

// [shared/pwis_pkg.sv]
// constants for the per-port wake and interrupt status block
`default_nettype none
package pwis_pkg;
    // register indices inside one port page (avalon word address [7:0])
    localparam logic [7:0] OFF_WAKE_FLAGS = 8'h13;
    localparam logic [7:0] OFF_WAKE_EN    = 8'h17;
    localparam logic [7:0] OFF_IRQ_STAT   = 8'h1b;
    localparam logic [7:0] OFF_IRQ_MASK   = 8'h1f;
    localparam logic [7:0] OFF_EVT_STAT   = 8'hf0;
    localparam logic [7:0] OFF_EVT_MASK   = 8'hf1;
    // port page select sits in address [15:12]
    localparam int         PAGE_LSB       = 12;
    localparam logic [3:0] PORT_MAC_IDX   = 4'h7;
    localparam logic [3:0] PORT_PHY_FIRST = 4'h1;
    localparam logic [3:0] PORT_PHY_LAST  = 4'h4;
    // wake flag / enable bit positions
    localparam int WAKE_ENERGY_BIT = 0;
    localparam int WAKE_LINK_BIT   = 1;
    localparam int WAKE_FRAME_BIT  = 2;
    // port interrupt status / mask bit positions
    localparam int IRQ_FILTER_BIT  = 0;
    localparam int IRQ_XCVR_BIT    = 1;
    localparam int IRQ_TS_BIT      = 2;
    // sticky event status bit positions
    localparam int EVT_ENERGY_BIT  = 0;
    localparam int EVT_LINK_BIT    = 1;
    localparam int EVT_FRAME_BIT   = 2;
    localparam int EVT_FILTER_BIT  = 3;
    // reset values
    localparam logic [2:0]  RST_WAKE_FLAGS = 3'h0;
    localparam logic [2:0]  RST_WAKE_EN    = 3'h0;
    localparam logic [2:0]  RST_IRQ_MASK   = 3'h0;
    localparam logic [3:0]  RST_EVT_MASK   = 4'h0;
    localparam logic [31:0] RST_RDATA      = 32'h0000_0000;
    localparam logic [3:0]  RST_EVT_STAT   = 4'h0;
    localparam logic        RST_FILT_STAT  = 1'b0;
    localparam logic        RST_WAIT       = 1'b1;
    localparam logic        RST_OUT        = 1'b0;
    // station address width
    localparam int MAC_ADDR_W = 48;
endpackage : pwis_pkg
`default_nettype wire
